// ===== rtl/usbdps_top.sv
// device event status, port control/status and run/halt state of the device port
// assumes a 16-bit memory-mapped port; every input is synchronous to clock_i
//
// Contract
// - resume from host sets bit 7; stays until software writes one.
// - bus suspend sets bit 6; write one clears, write zero does nothing.
// - bus reset sets bit 5; cleared only by writing one there.
// - system memory access error sets bit 3; cleared by writing one.
// - system error also clears run/stop and raises halted.
// - bit 1 reads high in full-speed mode, low otherwise.
// - bit 0 reads high in high-speed mode, low otherwise.
// - port test field bits 15:13 is read-write and selects the test mode.
// - bits 9:8 show live D+ and D- levels; reset value 10b.
// - connection status toggle sets change flag bit 1; write one clears.
// - bit 0 reports host connected; valid only with port bit 2 set. Here bit 2 stays reserved and bit 0 is always reported.
// - event status resets to 0000h, port register resets to 0200h.
// - run/stop set enables controller operation; clear stops it.

module usbdps_top
    import usbdps_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    // register port
    input wire logic mmio_req_i,
    input wire logic mmio_we_i,
    input wire logic [7:0] mmio_addr_i,
    input wire logic [1:0] mmio_be_i,
    input wire logic [15:0] mmio_wdata_i,
    output logic [15:0] mmio_rdata_o,
    output logic mmio_ack_o,
    // bus events and state from the port logic
    input wire logic resume_det_i,
    input wire logic suspend_det_i,
    input wire logic bus_reset_det_i,
    input wire logic sys_err_i,
    input wire logic fs_mode_i,
    input wire logic hs_mode_i,
    input wire logic line_dp_i,
    input wire logic line_dm_i,
    input wire logic connected_i,
    // controls toward the controller
    output logic [2:0] test_mode_o,
    output logic run_o,
    output logic halted_o
);

    // ==============================
    // access decode
    // the byte-select bit of the address is ignored, so both halves of a word hit
    logic wr_en;
    logic hit_ctrl;
    logic hit_event;
    logic hit_port;
    logic wr_event_lo;
    logic wr_port_lo;
    logic wr_port_hi;
    logic wr_ctrl_lo;

    assign wr_en = mmio_req_i & mmio_we_i;
    assign hit_ctrl = usbdps_hit(mmio_addr_i, USBDPS_CTRL_HI_OFFSET);
    assign hit_event = usbdps_hit(mmio_addr_i, USBDPS_EVENT_OFFSET);
    assign hit_port = usbdps_hit(mmio_addr_i, USBDPS_PORT_OFFSET);
    assign wr_event_lo = wr_en & hit_event & mmio_be_i[0];
    assign wr_port_lo = wr_en & hit_port & mmio_be_i[0];
    assign wr_port_hi = wr_en & hit_port & mmio_be_i[1];
    assign wr_ctrl_lo = wr_en & hit_ctrl & mmio_be_i[0];

    // ==============================
    // write-one-to-clear strobes
    // a strobe needs the low byte enable, since every flag sits in bits 7:0
    logic clr_resume;
    logic clr_suspend;
    logic clr_busrst;
    logic clr_syserr;
    logic clr_change;

    assign clr_resume = wr_event_lo & mmio_wdata_i[USBDPS_EV_RESUME_BIT];
    assign clr_suspend = wr_event_lo & mmio_wdata_i[USBDPS_EV_SUSPEND_BIT];
    assign clr_busrst = wr_event_lo & mmio_wdata_i[USBDPS_EV_BUSRST_BIT];
    assign clr_syserr = wr_event_lo & mmio_wdata_i[USBDPS_EV_SYSERR_BIT];
    assign clr_change = wr_port_lo & mmio_wdata_i[USBDPS_PT_CHG_BIT];

    // ==============================
    // sticky event flags
    // all of them clear on a write of one; an event in the clearing cycle wins
    logic resume_flag;
    logic suspend_flag;
    logic busrst_flag;
    logic syserr_flag;
    logic change_flag;
    logic conn_level;
    logic conn_toggle;

    usbdps_flag u_resume
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(resume_det_i),
        .clear_i(clr_resume),
        .flag_o(resume_flag)
    );

    usbdps_flag u_suspend
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(suspend_det_i),
        .clear_i(clr_suspend),
        .flag_o(suspend_flag)
    );

    usbdps_flag u_busrst
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(bus_reset_det_i),
        .clear_i(clr_busrst),
        .flag_o(busrst_flag)
    );

    usbdps_flag u_syserr
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(sys_err_i),
        .clear_i(clr_syserr),
        .flag_o(syserr_flag)
    );

    // connection status follows the input one cycle late, so the change flag
    // and the status bit turn over on the same edge
    // the held level resets low, so a host present at release shows as a change
    usbdps_change_det u_conn
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .level_i(connected_i),
        .level_o(conn_level),
        .toggle_o(conn_toggle)
    );

    usbdps_flag u_change
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(conn_toggle),
        .clear_i(clr_change),
        .flag_o(change_flag)
    );

    // ==============================
    // live status sampling
    logic fs_reg;
    logic hs_reg;
    logic [1:0] line_reg;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fs_reg <= 1'b0;
        else
            fs_reg <= fs_mode_i;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hs_reg <= 1'b0;
        else
            hs_reg <= hs_mode_i;
    end

    // the line pair resets to the idle full-speed level, D+ high and D- low
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            line_reg <= USBDPS_LINE_RESET;
        else
            line_reg <= {line_dp_i, line_dm_i};
    end

    // ==============================
    // port test mode
    // only the upper byte enable reaches the field; a write without it keeps
    // the running test mode
    logic [2:0] test_reg;
    logic [2:0] test_next;

    assign test_next = wr_port_hi ? mmio_wdata_i[USBDPS_PT_TEST_MSB:USBDPS_PT_TEST_LSB]
                                  : test_reg;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            test_reg <= USBDPS_TEST_NONE;
        else
            test_reg <= test_next;
    end

    // ==============================
    // run/stop and halted
    // a system error overrides a run write in the same cycle, so software
    // can never restart a controller that is faulting right now
    logic run_reg;
    logic run_next;
    logic halted_reg;
    logic halted_next;

    assign run_next = sys_err_i ? 1'b0
                    : (wr_ctrl_lo ? mmio_wdata_i[USBDPS_CT_RUN_BIT] : run_reg);
    assign halted_next = sys_err_i ? 1'b1 : (halted_reg & ~run_next);

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            run_reg <= 1'b0;
        else
            run_reg <= run_next;
    end

    // halted has no register bit of its own; it is seen only on halted_o
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            halted_reg <= 1'b0;
        else
            halted_reg <= halted_next;
    end

    // ==============================
    // read data assembly, reserved bits tied to zero
    logic [15:0] event_word;
    logic [15:0] port_word;
    logic [15:0] ctrl_word;
    logic [15:0] read_next;

    always_comb
    begin
        event_word = USBDPS_EVENT_RESET;
        event_word[USBDPS_EV_RESUME_BIT] = resume_flag;
        event_word[USBDPS_EV_SUSPEND_BIT] = suspend_flag;
        event_word[USBDPS_EV_BUSRST_BIT] = busrst_flag;
        event_word[USBDPS_EV_SYSERR_BIT] = syserr_flag;
        event_word[USBDPS_EV_FS_BIT] = fs_reg;
        event_word[USBDPS_EV_HS_BIT] = hs_reg;
    end

    // port bit 2 stays reserved here, so the connection bits are reported
    // whether or not a qualifier would be set
    always_comb
    begin
        port_word = 16'h0000;
        port_word[USBDPS_PT_TEST_MSB:USBDPS_PT_TEST_LSB] = test_reg;
        port_word[USBDPS_PT_DP_BIT] = line_reg[1];
        port_word[USBDPS_PT_DM_BIT] = line_reg[0];
        port_word[USBDPS_PT_CHG_BIT] = change_flag;
        port_word[USBDPS_PT_CONN_BIT] = conn_level;
    end

    // only run/stop of the upper controller word lives here; the rest reads zero
    always_comb
    begin
        ctrl_word = 16'h0000;
        ctrl_word[USBDPS_CT_RUN_BIT] = run_reg;
    end

    // unmapped addresses answer zero but are still acknowledged
    assign read_next = hit_event ? event_word
                     : hit_port ? port_word
                     : hit_ctrl ? ctrl_word
                     : 16'h0000;

    // ==============================
    // answer registers
    // read data is reloaded only by a read, so a later write cannot disturb
    // a value that software has not yet picked up
    logic rd_en;
    logic [15:0] rdata_reg;
    logic ack_reg;

    assign rd_en = mmio_req_i & ~mmio_we_i;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= mmio_req_i;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_reg <= 16'h0000;
        else if (rd_en)
            rdata_reg <= read_next;
    end

    assign mmio_rdata_o = rdata_reg;
    assign mmio_ack_o = ack_reg;
    assign test_mode_o = test_reg;
    assign run_o = run_reg;
    assign halted_o = halted_reg;

endmodule

// ===== rtl/usbdps_pkg.sv
// constants, field layout and types shared by the port status block
// assumes byte offsets on a 16-bit memory-mapped register port

package usbdps_pkg;

    // ==============================
    // register offsets (byte addresses, 16-bit words)
    localparam logic [7:0] USBDPS_CTRL_HI_OFFSET = 8'h12;
    localparam logic [7:0] USBDPS_EVENT_OFFSET = 8'h14;
    localparam logic [7:0] USBDPS_PORT_OFFSET = 8'h16;

    // ==============================
    // device event status fields
    localparam int USBDPS_EV_RESUME_BIT = 7;
    localparam int USBDPS_EV_SUSPEND_BIT = 6;
    localparam int USBDPS_EV_BUSRST_BIT = 5;
    localparam int USBDPS_EV_SYSERR_BIT = 3;
    localparam int USBDPS_EV_FS_BIT = 1;
    localparam int USBDPS_EV_HS_BIT = 0;
    localparam logic [15:0] USBDPS_EVENT_RESET = 16'h0000;

    // ==============================
    // port control/status fields
    localparam int USBDPS_PT_TEST_LSB = 13;
    localparam int USBDPS_PT_TEST_MSB = 15;
    localparam int USBDPS_PT_DP_BIT = 9;
    localparam int USBDPS_PT_DM_BIT = 8;
    localparam int USBDPS_PT_CHG_BIT = 1;
    localparam int USBDPS_PT_CONN_BIT = 0;
    localparam logic [15:0] USBDPS_PORT_RESET = 16'h0200;
    localparam logic [1:0] USBDPS_LINE_RESET = 2'b10;

    // ==============================
    // upper controller word: run/stop is bit 16 of the long word, bit 0 here
    localparam int USBDPS_CT_RUN_BIT = 0;

    typedef enum logic [2:0] {
        USBDPS_TEST_NONE = 3'b000,
        USBDPS_TEST_J = 3'b001,
        USBDPS_TEST_K = 3'b010,
        USBDPS_TEST_SE0_NAK = 3'b011,
        USBDPS_TEST_PACKET = 3'b100,
        USBDPS_TEST_FORCE_EN = 3'b101,
        USBDPS_TEST_CHIRP_J = 3'b110,
        USBDPS_TEST_CHIRP_K = 3'b111
    } usbdps_test_type;

    // word hit ignores the byte-select bit of the address
    function automatic logic usbdps_hit(input logic [7:0] addr, input logic [7:0] offset);
        usbdps_hit = (addr[7:1] == offset[7:1]);
    endfunction

endpackage

// ===== rtl/usbdps_flag.sv
// one sticky event flag, cleared by a write of one
// assumes set and clear are single-cycle strobes on clock_i

module usbdps_flag
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);

    // ==============================
    // flag state
    logic flag_reg;
    logic flag_next;

    // an event in the clearing cycle is kept: set wins
    assign flag_next = set_i | (flag_reg & ~clear_i);
    assign flag_o = flag_reg;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

endmodule

// ===== rtl/usbdps_change_det.sv
// holds a level and flags the cycle in which the incoming level differs
// assumes level_i is synchronous to clock_i

module usbdps_change_det
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic level_o,
    output logic toggle_o
);

    // ==============================
    // held level and change detect
    logic level_reg;

    assign toggle_o = level_i ^ level_reg;
    assign level_o = level_reg;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            level_reg <= 1'b0;
        else
            level_reg <= level_i;
    end

endmodule

// ===== verif/usbdps_top_chk.sv
// assertions on the port status block, seen from its ports only
// assumes a bind onto usbdps_top and one clock domain
module usbdps_top_chk
    import usbdps_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mmio_req_i,
    input wire logic mmio_we_i,
    input wire logic [7:0] mmio_addr_i,
    input wire logic [1:0] mmio_be_i,
    input wire logic [15:0] mmio_wdata_i,
    input wire logic [15:0] mmio_rdata_o,
    input wire logic sys_err_i,
    input wire logic fs_mode_i,
    input wire logic hs_mode_i,
    input wire logic line_dp_i,
    input wire logic line_dm_i,
    input wire logic [2:0] test_mode_o,
    input wire logic run_o,
    input wire logic halted_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================
    // access decode
    wire rd = mmio_req_i && !mmio_we_i;
    wire wr = mmio_req_i && mmio_we_i;
    wire rd_ev = rd && mmio_addr_i[7:1] == USBDPS_EVENT_OFFSET[7:1];
    wire rd_pt = rd && mmio_addr_i[7:1] == USBDPS_PORT_OFFSET[7:1];
    wire wr_pt = wr && mmio_be_i[1] && mmio_addr_i[7:1] == USBDPS_PORT_OFFSET[7:1];
    wire wr_ct = wr && mmio_be_i[0] && mmio_addr_i[7:1] == USBDPS_CTRL_HI_OFFSET[7:1];
    // nothing of this block lives at 0x20 or above
    wire rd_un = rd && mmio_addr_i[7:5] != 3'h0;

    // ==============================
    // properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_syserr_halts: assert property (sys_err_i |=> !run_o && halted_o)
        else $error("run not stopped by system error");
    a_run_unhalts: assert property ($rose(run_o) |-> !halted_o)
        else $error("halted stays with run set");
    a_run_write: assert property (wr_ct && !sys_err_i |=> run_o == $past(mmio_wdata_i[0]))
        else $error("run bit not written");
    a_test_write: assert property (wr_pt |=> test_mode_o == $past(mmio_wdata_i[15:13]))
        else $error("test field not written");
    a_test_holds: assert property (!wr_pt |=> $stable(test_mode_o))
        else $error("test field moved without write");
    a_line_read: assert property (rd_pt |=> mmio_rdata_o[9:8] == $past({line_dp_i, line_dm_i}, 2))
        else $error("line levels misreported");
    a_fs_read: assert property (rd_ev |=> mmio_rdata_o[1] == $past(fs_mode_i, 2))
        else $error("full speed bit misreported");
    a_hs_read: assert property (rd_ev |=> mmio_rdata_o[0] == $past(hs_mode_i, 2))
        else $error("high speed bit misreported");
    a_unmapped_zero: assert property (rd_un |=> mmio_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind usbdps_top usbdps_top_chk u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mmio_req_i(mmio_req_i), .mmio_we_i(mmio_we_i),
    .mmio_addr_i(mmio_addr_i), .mmio_be_i(mmio_be_i), .mmio_wdata_i(mmio_wdata_i),
    .mmio_rdata_o(mmio_rdata_o), .sys_err_i(sys_err_i), .fs_mode_i(fs_mode_i),
    .hs_mode_i(hs_mode_i), .line_dp_i(line_dp_i), .line_dm_i(line_dm_i),
    .test_mode_o(test_mode_o), .run_o(run_o), .halted_o(halted_o)
);

// ===== verif/usbdps_host_model.sv
// far-side model: bus events, speed, line levels and connection
// assumes the bench calls its tasks; outputs move only at rising edges
module usbdps_host_model
(
    input wire logic clock_i,
    output logic resume_o,
    output logic suspend_o,
    output logic bus_reset_o,
    output logic sys_err_o,
    output logic [4:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================
    // lvl_o is fs, hs, d+, d-, connected; idle bus shows d+ high
    initial
    begin
        {resume_o, suspend_o, bus_reset_o, sys_err_o} = 4'h0;
        lvl_o = 5'h04;
    end
    // system error really comes from the memory side; driven here to keep one source
    task automatic pulse(input int b);
        @(posedge clock_i);
        case (b)
            0: resume_o <= 1'b1;
            1: suspend_o <= 1'b1;
            2: bus_reset_o <= 1'b1;
            default: sys_err_o <= 1'b1;
        endcase
        @(posedge clock_i);
        {resume_o, suspend_o, bus_reset_o, sys_err_o} <= 4'h0;
    endtask
    task automatic level(input logic [4:0] v);
        @(posedge clock_i);
        lvl_o <= v;
    endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the device port status block
// assumes usbdps_top, its checker and the host model are compiled first
module tb
    import usbdps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, rst_n_i, req, we, ack, run, halted, res, sus, brst, serr;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata, rdata, q;
    logic [2:0] tm;
    logic [4:0] lv;
    logic [15:0] ev_tbl [4] = '{16'h0080, 16'h0040, 16'h0020, 16'h0008};
    int n_fail, tests_run;

    usbdps_host_model host (.clock_i(clock_i), .resume_o(res), .suspend_o(sus),
        .bus_reset_o(brst), .sys_err_o(serr), .lvl_o(lv));
    usbdps_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .mmio_req_i(req), .mmio_we_i(we),
        .mmio_addr_i(addr), .mmio_be_i(be), .mmio_wdata_i(wdata), .mmio_rdata_o(rdata),
        .mmio_ack_o(ack), .resume_det_i(res), .suspend_det_i(sus), .bus_reset_det_i(brst),
        .sys_err_i(serr), .fs_mode_i(lv[4]), .hs_mode_i(lv[3]), .line_dp_i(lv[2]),
        .line_dm_i(lv[1]), .connected_i(lv[0]), .test_mode_o(tm), .run_o(run),
        .halted_o(halted));

    // ==============================
    // clock and access tasks
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] b,
        input logic [15:0] d);
        int i;
        @(posedge clock_i);
        req <= 1'b1;
        we <= w;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clock_i);
        req <= 1'b0;
        #1;
        for (i = 0; i < 4 && ack !== 1'b1; i++)
        begin
            @(posedge clock_i);
            #1;
        end
        if (i == 4)
        begin
            n_fail++;
            tally_and_finish();
        end
        q = rdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        acc(1'b0, a, 2'b00, 16'h0000);
        chk(name, q, exp);
    endtask

    // ==============================
    // scenarios
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst_n_i = 1'b0;
        req = 1'b0;
        we = 1'b0;
        addr = 8'h00;
        be = 2'b00;
        wdata = 16'h0000;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(8'h14, 16'h0000, "event reset");
        rd(8'h16, 16'h0200, "port reset");
        acc(1'b1, 8'h12, 2'b01, 16'h0001);
        chk("run", {15'h0000, run}, 16'h0001);
        // last pass is the system error, which must also stop the run
        for (int b = 0; b < 4; b++)
        begin
            host.pulse(b);
            rd(8'h14, ev_tbl[b], "flag set");
            acc(1'b1, 8'h14, 2'b11, 16'h0000);
            rd(8'h14, ev_tbl[b], "flag after zero");
            acc(1'b1, 8'h14, 2'b01, ev_tbl[b]);
            rd(8'h14, 16'h0000, "flag clear");
        end
        chk("stopped", {14'h0000, run, halted}, 16'h0001);
        acc(1'b1, 8'h12, 2'b01, 16'h0001);
        chk("restart", {14'h0000, run, halted}, 16'h0002);
        host.level(5'h14);
        rd(8'h14, 16'h0002, "full speed");
        host.level(5'h0C);
        rd(8'h14, 16'h0001, "high speed");
        acc(1'b1, 8'h14, 2'b11, 16'hFF17);
        rd(8'h14, 16'h0001, "event reserved");
        host.level(5'h0B);
        rd(8'h16, 16'h0103, "connect");
        acc(1'b1, 8'h16, 2'b01, 16'h0002);
        rd(8'h16, 16'h0101, "change clear");
        host.level(5'h0A);
        rd(8'h16, 16'h0102, "disconnect");
        for (int t = 0; t < 8; t++)
        begin
            acc(1'b1, 8'h16, 2'b10, 16'(t) << 13);
            chk("test mode", {13'h0000, tm}, 16'(t));
        end
        rd(8'h16, 16'hE102, "test readback");
        acc(1'b1, 8'h16, 2'b11, 16'h1CFC);
        rd(8'h16, 16'h0102, "port reserved");
        rd(8'h20, 16'h0000, "unmapped");
        acc(1'b1, 8'h16, 2'b10, 16'hE000);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("reset mid run", {11'h000, tm, run, halted}, 16'h0000);
        chk("ack in reset", {15'h0000, ack}, 16'h0000);
        chk("rdata in reset", rdata, 16'h0000);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(8'h16, 16'h0100, "port after reset");
        rd(8'h14, 16'h0001, "event after reset");
        tally_and_finish();
    end
endmodule
